// *** src/rdov_pkg.sv ***
`default_nettype none

package rdov_pkg;

	// ****************************************************************
	// Types.
	// ****************************************************************
	typedef enum logic {RDOV_OPER_OFF, RDOV_OPER_ON} rdov_oper_t;
	typedef enum logic [1:0] {RDOV_ST_IDLE, RDOV_ST_TIMING, RDOV_ST_TRIPPED} rdov_state_t;

	// ****************************************************************
	// Widths.
	// ****************************************************************
	localparam int VOLT_W = 16;
	localparam int PCT_W = 6;
	localparam int RATIO_W = 4;
	localparam int DELAY_W = 16;
	localparam int PRESC_W = 17;

	// ****************************************************************
	// Setting ranges and defaults.
	// ****************************************************************
	localparam logic [PCT_W-1:0] THR_MIN = 6'h02;
	localparam logic [PCT_W-1:0] THR_MAX = 6'h3c;
	localparam logic [PCT_W-1:0] THR_DEF = 6'h1e;
	localparam logic [RATIO_W-1:0] RATIO_MIN = 4'h1;
	localparam logic [RATIO_W-1:0] RATIO_MAX = 4'ha;
	localparam logic [RATIO_W-1:0] RATIO_DEF = 4'h5;
	localparam logic [DELAY_W-1:0] DELAY_MAX = 16'hea60;
	localparam logic [DELAY_W-1:0] DELAY_DEF = 16'h0064;
	localparam rdov_oper_t OPER_DEF = RDOV_OPER_ON;
	localparam logic START_ONLY_DEF = 1'h0;

	// ****************************************************************
	// Scaling. The voltage input counts hundredths of a percent.
	// ****************************************************************
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam logic [6:0] VOLT_SCALE = 7'h64;

	// ****************************************************************
	// Timing.
	// ****************************************************************
	localparam int MS_NS = 1000000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

endpackage : rdov_pkg

`default_nettype wire

// *** src/rdov_tmr_if.sv ***
`default_nettype none

interface rdov_tmr_if;
	logic run;
	logic [rdov_pkg::DELAY_W-1:0] delay_ms;
	logic done;
	logic [rdov_pkg::DELAY_W-1:0] elapsed_ms;

	modport ctrl (output run, output delay_ms, input done, input elapsed_ms);
	modport timer (input run, input delay_ms, output done, output elapsed_ms);
endinterface : rdov_tmr_if

`default_nettype wire

// *** src/rdov_timer.sv ***
`default_nettype none

module rdov_timer #(
	parameter int unsigned CYCLES_PER_MS = rdov_pkg::MS_CYCLES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	rdov_tmr_if.timer bus
);

	logic [rdov_pkg::PRESC_W-1:0] presc_reg;
	logic [rdov_pkg::PRESC_W-1:0] presc_next;
	logic [rdov_pkg::DELAY_W-1:0] elapsed_reg;
	logic [rdov_pkg::DELAY_W-1:0] elapsed_next;
	logic done_reg;
	logic done_next;
	logic ms_tick;

	// ****************************************************************
	// Millisecond prescaler and elapsed time counter.
	// ****************************************************************
	always_comb
	begin
		ms_tick = bus.run && (presc_reg == rdov_pkg::PRESC_W'(CYCLES_PER_MS - 1));
		if (!bus.run || ms_tick)
		begin
			presc_next = '0;
		end
		else
		begin
			presc_next = presc_reg + rdov_pkg::PRESC_W'(1);
		end
		if (!bus.run)
		begin
			elapsed_next = '0;
		end
		else if (ms_tick && (elapsed_reg != '1))
		begin
			elapsed_next = elapsed_reg + rdov_pkg::DELAY_W'(1);
		end
		else
		begin
			elapsed_next = elapsed_reg;
		end
		done_next = bus.run && (elapsed_next >= bus.delay_ms);
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			presc_reg <= '0;
			elapsed_reg <= '0;
			done_reg <= 1'b0;
		end
		else
		begin
			presc_reg <= presc_next;
			elapsed_reg <= elapsed_next;
			done_reg <= done_next;
		end
	end

	assign bus.done = done_reg;
	assign bus.elapsed_ms = elapsed_reg;

endmodule : rdov_timer

`default_nettype wire

// *** src/rdov_top.sv ***
`default_nettype none

module rdov_top #(
	parameter int unsigned CYCLES_PER_MS = rdov_pkg::MS_CYCLES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [rdov_pkg::VOLT_W-1:0] residual_voltage_rms,
	input wire rdov_pkg::rdov_oper_t operation_switch,
	input wire logic [rdov_pkg::PCT_W-1:0] start_threshold_pct,
	input wire logic [rdov_pkg::RATIO_W-1:0] dropoff_ratio_pct,
	input wire logic [rdov_pkg::DELAY_W-1:0] trip_delay_ms,
	input wire logic start_only_select,
	input wire logic block_input,
	output logic start_flag,
	output logic trip_flag,
	output logic general_start_out,
	output logic general_trip_out
);

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	logic fn_enabled;
	logic [rdov_pkg::PCT_W-1:0] thr_eff;
	logic [rdov_pkg::RATIO_W-1:0] ratio_eff;
	logic [rdov_pkg::DELAY_W-1:0] delay_eff;
	logic [rdov_pkg::VOLT_W-1:0] thr_level;
	logic [rdov_pkg::VOLT_W-1:0] drop_level;
	logic above_thr;
	logic below_drop;

	rdov_pkg::rdov_state_t state_reg;
	rdov_pkg::rdov_state_t state_next;
	logic start_reg;
	logic start_next;
	logic trip_reg;
	logic trip_next;
	logic gen_start_reg;
	logic gen_start_next;
	logic gen_trip_reg;
	logic gen_trip_next;

	rdov_tmr_if tmr ();

	// ****************************************************************
	// Setting limits and comparison levels.
	// ****************************************************************
	always_comb
	begin
		if (start_threshold_pct < rdov_pkg::THR_MIN)
		begin
			thr_eff = rdov_pkg::THR_MIN;
		end
		else if (start_threshold_pct > rdov_pkg::THR_MAX)
		begin
			thr_eff = rdov_pkg::THR_MAX;
		end
		else
		begin
			thr_eff = start_threshold_pct;
		end
		if (dropoff_ratio_pct < rdov_pkg::RATIO_MIN)
		begin
			ratio_eff = rdov_pkg::RATIO_MIN;
		end
		else if (dropoff_ratio_pct > rdov_pkg::RATIO_MAX)
		begin
			ratio_eff = rdov_pkg::RATIO_MAX;
		end
		else
		begin
			ratio_eff = dropoff_ratio_pct;
		end
		if (trip_delay_ms > rdov_pkg::DELAY_MAX)
		begin
			delay_eff = rdov_pkg::DELAY_MAX;
		end
		else
		begin
			delay_eff = trip_delay_ms;
		end
		thr_level = rdov_pkg::VOLT_W'(thr_eff) * rdov_pkg::VOLT_W'(rdov_pkg::VOLT_SCALE);
		drop_level = rdov_pkg::VOLT_W'(thr_eff)
			* rdov_pkg::VOLT_W'(rdov_pkg::PCT_FULL - 7'(ratio_eff));
		above_thr = residual_voltage_rms > thr_level;
		below_drop = residual_voltage_rms < drop_level;
		fn_enabled = (operation_switch == rdov_pkg::RDOV_OPER_ON) && !block_input;
	end

	// ****************************************************************
	// Delay timer.
	// ****************************************************************
	// Timing runs only while started and enabled, so loss of either clears it.
	assign tmr.run = (state_reg != rdov_pkg::RDOV_ST_IDLE) && fn_enabled;
	assign tmr.delay_ms = delay_eff;

	rdov_timer #(
		.CYCLES_PER_MS(CYCLES_PER_MS)
	) i_rdov_timer (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.bus(tmr)
	);

	// ****************************************************************
	// Characteristic and decision logic.
	// ****************************************************************
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			rdov_pkg::RDOV_ST_IDLE:
			begin
				if (fn_enabled && above_thr)
				begin
					state_next = rdov_pkg::RDOV_ST_TIMING;
				end
			end
			rdov_pkg::RDOV_ST_TIMING:
			begin
				if (!fn_enabled || below_drop)
				begin
					state_next = rdov_pkg::RDOV_ST_IDLE;
				end
				else if (tmr.done)
				begin
					state_next = rdov_pkg::RDOV_ST_TRIPPED;
				end
			end
			rdov_pkg::RDOV_ST_TRIPPED:
			begin
				if (!fn_enabled || below_drop)
				begin
					state_next = rdov_pkg::RDOV_ST_IDLE;
				end
			end
			default:
			begin
				state_next = rdov_pkg::RDOV_ST_IDLE;
			end
		endcase
		start_next = state_next != rdov_pkg::RDOV_ST_IDLE;
		trip_next = state_next == rdov_pkg::RDOV_ST_TRIPPED;
		gen_start_next = start_next;
		gen_trip_next = trip_next && !start_only_select;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg <= rdov_pkg::RDOV_ST_IDLE;
			start_reg <= 1'b0;
			trip_reg <= 1'b0;
			gen_start_reg <= 1'b0;
			gen_trip_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			start_reg <= start_next;
			trip_reg <= trip_next;
			gen_start_reg <= gen_start_next;
			gen_trip_reg <= gen_trip_next;
		end
	end

	assign start_flag = start_reg;
	assign trip_flag = trip_reg;
	assign general_start_out = gen_start_reg;
	assign general_trip_out = gen_trip_reg;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge clk_sys);
	endclocking

	default disable iff (sys_rst);

	sequence s_pickup;
		fn_enabled && !start_flag && above_thr;
	endsequence

	sequence s_started;
		start_flag && general_start_out;
	endsequence

	sequence s_quiet;
		!start_flag && !trip_flag && !general_start_out && !general_trip_out;
	endsequence

	property p_start_pickup;
		s_pickup |=> s_started;
	endproperty
	a_start_pickup: assert property (p_start_pickup)
		else $error("Start did not follow a voltage above threshold.");

	property p_start_level;
		$rose(start_flag) |-> ($past(thr_eff) >= rdov_pkg::THR_MIN)
			&& ($past(thr_eff) <= rdov_pkg::THR_MAX)
			&& ($past(residual_voltage_rms) > $past(thr_level));
	endproperty
	a_start_level: assert property (p_start_level)
		else $error("Start raised without voltage above a legal threshold.");

	property p_trip_delay;
		$rose(trip_flag) |-> ($past(tmr.elapsed_ms) >= $past(delay_eff))
			&& ($past(delay_eff) <= rdov_pkg::DELAY_MAX);
	endproperty
	a_trip_delay: assert property (p_trip_delay)
		else $error("Trip raised before the delay had elapsed.");

	property p_trip_on_done;
		start_flag && !trip_flag && fn_enabled && tmr.done && !below_drop |=> trip_flag;
	endproperty
	a_trip_on_done: assert property (p_trip_on_done)
		else $error("Trip missing after the delay ran out.");

	property p_trip_cause;
		$rose(trip_flag) |-> $past(tmr.done) && $past(start_flag);
	endproperty
	a_trip_cause: assert property (p_trip_cause)
		else $error("Trip raised without a started and expired timer.");

	property p_oper_off;
		operation_switch == rdov_pkg::RDOV_OPER_OFF |=> s_quiet;
	endproperty
	a_oper_off: assert property (p_oper_off)
		else $error("Output active while operation is off.");

	property p_start_only;
		start_only_select |=> !general_trip_out;
	endproperty
	a_start_only: assert property (p_start_only)
		else $error("General trip issued in start-only mode.");

	property p_gen_trip;
		general_trip_out == (trip_flag && !$past(start_only_select));
	endproperty
	a_gen_trip: assert property (p_gen_trip)
		else $error("General trip does not match trip and start-only.");

	property p_block;
		block_input |=> s_quiet;
	endproperty
	a_block: assert property (p_block)
		else $error("Output active while blocked.");

	property p_gen_start;
		general_start_out == start_flag;
	endproperty
	a_gen_start: assert property (p_gen_start)
		else $error("General start differs from start.");

	property p_dropoff;
		start_flag && fn_enabled && below_drop |=> !start_flag;
	endproperty
	a_dropoff: assert property (p_dropoff)
		else $error("Start held below the drop-off level.");

	property p_hold;
		start_flag && fn_enabled && !below_drop |=> start_flag;
	endproperty
	a_hold: assert property (p_hold)
		else $error("Start dropped above the drop-off level.");

	property p_restart;
		$fell(start_flag) |-> !trip_flag ##1 (tmr.elapsed_ms == '0);
	endproperty
	a_restart: assert property (p_restart)
		else $error("Timer not cleared after start was lost.");

	property p_disabled_clear;
		!fn_enabled |=> (tmr.elapsed_ms == '0) && !tmr.done;
	endproperty
	a_disabled_clear: assert property (p_disabled_clear)
		else $error("Timer running while off or blocked.");

endmodule : rdov_top

`default_nettype wire

// *** verification/rdov_far_model.sv ***
`default_nettype none

module rdov_far_model (
	input wire logic clk_sys,
	output var logic [rdov_pkg::VOLT_W-1:0] residual_voltage_rms,
	output var logic block_input
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		residual_voltage_rms = 16'h0000;
		block_input = 1'h0;
	end

	// ****************************************************************
	// Measurement level and user blocking equation, both changed off the sampling edge.
	// ****************************************************************
	task automatic apply(input logic [rdov_pkg::VOLT_W-1:0] volt, input logic blk);
		@(negedge clk_sys);
		residual_voltage_rms = volt;
		block_input = blk;
	endtask : apply

endmodule : rdov_far_model

`default_nettype wire

// *** verification/rdov_top_tb.sv ***
`default_nettype none

module rdov_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int C = 4;
	localparam int LIMIT = 2000;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	rdov_pkg::rdov_oper_t oper = rdov_pkg::OPER_DEF;
	logic [rdov_pkg::PCT_W-1:0] thr = rdov_pkg::THR_DEF;
	logic [rdov_pkg::RATIO_W-1:0] ratio = rdov_pkg::RATIO_DEF;
	logic [rdov_pkg::DELAY_W-1:0] dly = rdov_pkg::DELAY_DEF;
	logic st_only = rdov_pkg::START_ONLY_DEF;
	logic [rdov_pkg::VOLT_W-1:0] volt;
	logic blk;
	logic st, tr, gst, gtr;
	int n_mismatch = 0;
	int n_compared = 0;
	int cycles = 0;
	int k, lim, rc, tc;
	logic [5:0] thr_tab [5] = '{6'h1e, 6'h02, 6'h3c, 6'h01, 6'h3f};
	logic [15:0] dl_tab [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0005};
	logic [3:0] rt_tab [4] = '{4'h5, 4'h1, 4'ha, 4'hf};

	always #4 clk_sys = ~clk_sys;

	rdov_far_model i_rdov_far_model (
		.clk_sys(clk_sys),
		.residual_voltage_rms(volt),
		.block_input(blk)
	);

	rdov_top #(.CYCLES_PER_MS(C)) i_rdov_top (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.residual_voltage_rms(volt),
		.operation_switch(oper),
		.start_threshold_pct(thr),
		.dropoff_ratio_pct(ratio),
		.trip_delay_ms(dly),
		.start_only_select(st_only),
		.block_input(blk),
		.start_flag(st),
		.trip_flag(tr),
		.general_start_out(gst),
		.general_trip_out(gtr)
	);

	// ****************************************************************
	// Shared tasks.
	// ****************************************************************
	task automatic tally_and_finish();
		$display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : wait_cyc

	// Outputs are compared as start, trip, general start, general trip.
	task automatic chk(input logic [3:0] exp);
		n_compared++;
		if ({st, tr, gst, gtr} !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: outputs %b expected %b", $time, {st, tr, gst, gtr}, exp);
		end
	endtask : chk

	// Applies a level above threshold and checks start, then the trip moment.
	task automatic pickup_trip(input int kk, input logic [3:0] tripped);
		i_rdov_far_model.apply(16'h0bb9, 1'h0);
		wait_cyc(1);
		chk(4'ha);
		wait_cyc(kk);
		chk(4'ha);
		wait_cyc(1);
		chk(tripped);
	endtask : pickup_trip

	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// ****************************************************************
	// Test sequence.
	// ****************************************************************
	initial
	begin
		wait_cyc(3);
		sys_rst = 1'h0;
		chk(4'h0);
		foreach (thr_tab[i])
		begin
			tc = (thr_tab[i] < 2) ? 2 : ((thr_tab[i] > 60) ? 60 : int'(thr_tab[i]));
			lim = tc * 100;
			thr = thr_tab[i];
			i_rdov_far_model.apply(16'(lim), 1'h0);
			wait_cyc(1);
			chk(4'h0);
			i_rdov_far_model.apply(16'(lim + 1), 1'h0);
			wait_cyc(1);
			chk(4'ha);
			i_rdov_far_model.apply(16'h0000, 1'h0);
			wait_cyc(2);
			chk(4'h0);
		end
		thr = rdov_pkg::THR_DEF;
		foreach (dl_tab[i])
		begin
			dly = dl_tab[i];
			ratio = rt_tab[i];
			rc = (rt_tab[i] > 10) ? 10 : int'(rt_tab[i]);
			k = (C * int'(dl_tab[i]) < 1) ? 1 : C * int'(dl_tab[i]);
			pickup_trip(k, 4'hf);
			wait_cyc(3);
			chk(4'hf);
			i_rdov_far_model.apply(16'(30 * (100 - rc)), 1'h0);
			wait_cyc(1);
			chk(4'hf);
			i_rdov_far_model.apply(16'(30 * (100 - rc) - 1), 1'h0);
			wait_cyc(1);
			chk(4'h0);
			wait_cyc(2);
		end
		// Early loss of start must restart the delay from zero.
		dly = 16'h0002;
		ratio = rdov_pkg::RATIO_DEF;
		i_rdov_far_model.apply(16'h0bb9, 1'h0);
		wait_cyc(5);
		i_rdov_far_model.apply(16'h0000, 1'h0);
		wait_cyc(1);
		chk(4'h0);
		wait_cyc(2);
		pickup_trip(8, 4'hf);
		i_rdov_far_model.apply(16'h0000, 1'h0);
		wait_cyc(3);
		st_only = 1'h1;
		pickup_trip(8, 4'he);
		wait_cyc(3);
		chk(4'he);
		st_only = 1'h0;
		i_rdov_far_model.apply(16'h0000, 1'h0);
		wait_cyc(3);
		// Operation off, then blocking, while tripped; timing must restart after each.
		for (int i = 0; i < 2; i++)
		begin
			pickup_trip(8, 4'hf);
			if (i == 0)
				oper = rdov_pkg::RDOV_OPER_OFF;
			else
				i_rdov_far_model.apply(16'h0bb9, 1'h1);
			wait_cyc(1);
			chk(4'h0);
			wait_cyc(3);
			chk(4'h0);
			i_rdov_far_model.apply(16'h0000, 1'h0);
			oper = rdov_pkg::RDOV_OPER_ON;
			pickup_trip(8, 4'hf);
			i_rdov_far_model.apply(16'h0000, 1'h0);
			wait_cyc(3);
		end
		tally_and_finish();
	end

endmodule : rdov_top_tb

`default_nettype wire
